// File: rtl/ext_regs_pkg.sv
// package: register indices, field positions, codes and reset values
// for the indirect access and link status register bank.
// assumes a 32-bit avalon-mm slave with one word per register index.
package ext_regs_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_ACCESS_CTRL = 6'h0d;
  localparam logic [5:0] IDX_ADDR_DATA   = 6'h0e;
  localparam logic [5:0] IDX_LINK_DROP   = 6'h0f;
  localparam logic [5:0] IDX_PHY_STATE   = 6'h10;
  localparam logic [5:0] IDX_RX_ERR_CNT  = 6'h15;
  localparam logic [5:0] IDX_TENBASE     = 6'h1a;
  localparam logic [5:0] IDX_DROP_ENABLE = 6'h20;
  localparam logic [5:0] IDX_IRQ_STATUS  = 6'h21;
  localparam logic [5:0] IDX_IRQ_CLEAR   = 6'h22;
  localparam logic [5:0] IDX_IRQ_ENABLE  = 6'h23;

  // manageable device select codes
  localparam logic [4:0] DEV_PCS     = 5'h03;
  localparam logic [4:0] DEV_AUTONEG = 5'h07;
  localparam logic [4:0] DEV_VENDOR  = 5'h1f;
  localparam logic [15:0] VENDOR_TOP = 16'h04d1;

  // command field codes
  localparam logic [1:0] CMD_ADDRESS = 2'h0;
  localparam logic [1:0] CMD_DATA    = 2'h1;
  localparam logic [1:0] CMD_INC_RW  = 2'h2;
  localparam logic [1:0] CMD_INC_WR  = 2'h3;

  // field positions
  localparam int CMD_HI          = 15;
  localparam int CMD_LO          = 14;
  localparam int DEVSEL_HI       = 4;
  localparam int CAUSE_LO        = 4;
  localparam int CAUSE_W         = 5;
  localparam int SWAP_BIT        = 14;
  localparam int RXERR_BIT       = 13;
  localparam int POL_BIT         = 12;
  localparam int TENBASE_POL_BIT = 4;
  localparam logic [15:0] CTRL_WMASK = 16'hc01f;

  // interrupt status bit positions
  localparam int IRQ_W         = 4;
  localparam int IRQ_LINK_DROP = 0;
  localparam int IRQ_RX_ERR    = 1;
  localparam int IRQ_POLARITY  = 2;
  localparam int IRQ_IGNORED   = 3;

  // values after reset
  localparam logic [15:0] CTRL_RST     = 16'h0000;
  localparam logic [15:0] PTR_RST      = 16'h000a;
  localparam logic [4:0]  DROP_EN_RST  = 5'h00;
  localparam logic [3:0]  IRQ_EN_RST   = 4'h0;
  localparam logic [15:0] RX_CNT_RST   = 16'h0000;
  localparam logic [15:0] STORE_RST    = 16'h0000;

endpackage : ext_regs_pkg

// File: rtl/mmd_store.sv
// one manageable device's register storage, a small array of words.
// assumes the caller only writes addresses inside the array.
`timescale 1ns/100ps
`default_nettype none

module mmd_store #(
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  // clock and reset
  input  wire logic          clock_in,
  input  wire logic          sys_rst_in,
  // access
  input  wire logic          wr_en_in,
  input  wire logic [AW-1:0] addr_in,
  input  wire logic [15:0]   wdata_in,
  output logic      [15:0]   rdata_out
);
  import ext_regs_pkg::*;

  logic [15:0] mem_ff [0:DEPTH-1];

  // storage write; reset clears every word so reads are defined
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      for (int k = 0; k < DEPTH; k++) begin
        mem_ff[k] <= STORE_RST;
      end
    end else if (wr_en_in) begin
      mem_ff[addr_in] <= wdata_in;
    end
  end

  // read is from flip-flops, no extra latency
  assign rdata_out = mem_ff[addr_in];

endmodule : mmd_store
`default_nettype wire

// File: rtl/phy_indirect_access_and_status.sv
// register bank: indirect access to three manageable devices, latched
// link-drop causes, phy state summary bits and an interrupt block.
// assumes all event and status inputs come from logic on clock_in.
`timescale 1ns/100ps
`default_nettype none

// Operation
// R1: devsel field picks target manageable device
// R2: all-ones select reaches vendor space up to top
// R3: codes 00011 and 00111 reach pcs, autoneg
// R4: other select codes: no effect, read zero
// R5: command 00 means pointer, else data port
// R6: cause bit latches on enabled link drop
// R7: cause order: sync, rxerr, mlt3, snr, energy
// R8: bit 14 shows mdi pair swap
// R9: bit 13 latches rx error, clears on counter read
// R10: bit 12 mirrors polarity latch, cleared elsewhere
// R11: polarity bit one when inverted polarity seen
// R12: command selects address, data, increment modes
// R13: link drops on or of enabled conditions
// R14: cause bits clear on status register read
module phy_indirect_access_and_status #(
  parameter int STORE_DEPTH = 16,
  parameter int STORE_AW    = 4
) (
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        sys_rst_in,
  // avalon-mm slave
  input  wire logic [7:0]  address_in,
  input  wire logic        read_in,
  input  wire logic        write_in,
  input  wire logic [31:0] writedata_in,
  input  wire logic [3:0]  byteenable_in,
  output logic      [31:0] readdata_out,
  output logic             waitrequest_out,
  // link-drop conditions: sync, rxerr, mlt3, snr, energy (msb first)
  input  wire logic [ext_regs_pkg::CAUSE_W-1:0] drop_condition_in,
  // phy status sources
  input  wire logic        mdi_swapped_in,
  input  wire logic        rx_error_event_in,
  input  wire logic        inverted_polarity_in,
  // outputs
  output logic             link_drop_out,
  output logic             irq_out
);
  import ext_regs_pkg::*;

  localparam logic [16:0] DEPTH_L = 17'(STORE_DEPTH);

  // bus slave state
  logic        ack_ff;
  logic [31:0] readdata_ff;
  logic [31:0] read_value;
  logic [5:0]  reg_idx;
  logic        rd_take;
  logic        wr_take;
  logic [15:0] wr_merged;

  // indirect access state
  logic [15:0] ctrl_ff;
  logic [15:0] ptr_ff   [0:2];
  logic [15:0] store_rd [0:2];
  logic [4:0]  devsel;
  logic [1:0]  cmd;
  logic [1:0]  mmd_idx;
  logic        dev_ok;
  logic [15:0] cur_ptr;
  logic        in_range;
  logic        store_hit;
  logic [15:0] ext_rd;
  logic        data_mode;
  logic        ad_read;
  logic        ad_write;
  logic        ad_ignored;
  logic        ptr_inc;

  // status state
  logic [CAUSE_W-1:0] cause_ff;
  logic [CAUSE_W-1:0] drop_en_ff;
  logic               link_drop_ff;
  logic               rx_err_latch_ff;
  logic [15:0]        rx_err_cnt_ff;
  logic               pol_latch_ff;
  logic               pol_view;
  logic [IRQ_W-1:0]   irq_stat_ff;
  logic [IRQ_W-1:0]   irq_en_ff;
  logic [IRQ_W-1:0]   irq_event;
  logic [CAUSE_W-1:0] drop_fire;

  // byte-lane merge of a 16-bit register with the low two lanes
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  be);
    logic [15:0] res;
    res = old_v;
    if (be[0]) begin
      res[7:0] = new_v[7:0];
    end
    if (be[1]) begin
      res[15:8] = new_v[15:8];
    end
    return res;
  endfunction : merge16

  // one wait state per access: request seen, then answered next cycle
  assign reg_idx         = address_in[7:2];
  assign waitrequest_out = (read_in | write_in) & ~ack_ff;
  assign rd_take         = read_in & ack_ff;
  assign wr_take         = write_in & ack_ff;
  assign readdata_out    = readdata_ff;

  // acknowledge toggles so back to back requests each get a wait state
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (read_in | write_in) & ~ack_ff;
    end
  end

  // read data captured one edge before the master takes it
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      readdata_ff <= 32'h0000_0000;
    end else if (read_in & ~ack_ff) begin
      readdata_ff <= read_value;
    end
  end

  // field decode of the control register
  assign devsel    = ctrl_ff[DEVSEL_HI:0];
  assign cmd       = ctrl_ff[CMD_HI:CMD_LO];
  assign data_mode = (cmd != CMD_ADDRESS);

  // R1: device select decode
  always_comb begin
    mmd_idx = 2'h0;
    dev_ok  = 1'b0;
    case (devsel)
      // R3: pcs and autoneg codes
      DEV_PCS: begin
        mmd_idx = 2'h0;
        dev_ok  = 1'b1;
      end
      DEV_AUTONEG: begin
        mmd_idx = 2'h1;
        dev_ok  = 1'b1;
      end
      // R2: vendor space code
      DEV_VENDOR: begin
        mmd_idx = 2'h2;
        dev_ok  = 1'b1;
      end
      // R4: unknown codes stay unselected
      default: begin
        mmd_idx = 2'h0;
        dev_ok  = 1'b0;
      end
    endcase
  end

  assign cur_ptr   = ptr_ff[mmd_idx];
  // R2: vendor window upper limit
  assign in_range  = (mmd_idx != 2'h2) || (cur_ptr <= VENDOR_TOP);
  // storage is shallower than the address space; the rest reads zero
  assign store_hit = {1'b0, cur_ptr} < DEPTH_L;
  assign ext_rd    = (dev_ok & in_range & store_hit) ? store_rd[mmd_idx] : 16'h0000;

  // accesses to the address/data register as they take effect
  assign ad_read    = rd_take & (reg_idx == IDX_ADDR_DATA);
  assign ad_write   = wr_take & (reg_idx == IDX_ADDR_DATA);
  // R4: ignored transaction detect
  assign ad_ignored = (ad_read | ad_write) & ~(dev_ok & (~data_mode | in_range));
  assign wr_merged  = merge16(data_mode ? ext_rd : cur_ptr, writedata_in, byteenable_in);

  // R12: post increment after data reads and writes per command
  always_comb begin
    ptr_inc = 1'b0;
    case (cmd)
      CMD_INC_RW: ptr_inc = (ad_read | ad_write) & dev_ok & in_range;
      CMD_INC_WR: ptr_inc = ad_write & dev_ok & in_range;
      CMD_DATA:   ptr_inc = 1'b0;
      default:    ptr_inc = 1'b0;
    endcase
  end

  // control register; reserved bits are never stored
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      ctrl_ff <= CTRL_RST;
    end else if (wr_take && reg_idx == IDX_ACCESS_CTRL) begin
      ctrl_ff <= merge16(ctrl_ff, writedata_in, byteenable_in) & CTRL_WMASK;
    end
  end

  // per-device pointer and storage
  generate
    for (genvar g = 0; g < 3; g++) begin : g_mmd
      logic sel_here;
      assign sel_here = dev_ok && (mmd_idx == 2'(g));

      // R5: pointer written in address mode, advanced by data access in the increment modes
      always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
          ptr_ff[g] <= PTR_RST;
        end else if (sel_here && ad_write && !data_mode) begin
          ptr_ff[g] <= wr_merged;
        end else if (sel_here && ptr_inc) begin
          ptr_ff[g] <= ptr_ff[g] + 16'h0001;
        end
      end

      // R5: data port writes reach storage
      mmd_store #(
        .DEPTH (STORE_DEPTH),
        .AW    (STORE_AW)
      ) u_store (
        .clock_in   (clock_in),
        .sys_rst_in (sys_rst_in),
        .wr_en_in   (sel_here & ad_write & data_mode & in_range & store_hit),
        .addr_in    (ptr_ff[g][STORE_AW-1:0]),
        .wdata_in   (wr_merged),
        .rdata_out  (store_rd[g])
      );
    end
  endgenerate

  // link-drop enables, one per condition
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      drop_en_ff <= DROP_EN_RST;
    end else if (wr_take && reg_idx == IDX_DROP_ENABLE && byteenable_in[0]) begin
      drop_en_ff <= writedata_in[CAUSE_W-1:0];
    end
  end

  assign drop_fire = drop_en_ff & drop_condition_in;

  // R13: link drop is the or of enabled conditions
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      link_drop_ff <= 1'b0;
    end else begin
      link_drop_ff <= |drop_fire;
    end
  end
  assign link_drop_out = link_drop_ff;

  // cause latches; set wins, and a read clears only the bits it returned
  generate
    for (genvar c = 0; c < CAUSE_W; c++) begin : g_cause
      // R6: latch high per enabled cause
      // R7: bit c follows condition input bit c
      // R14: cleared by status read, set wins
      always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
          cause_ff[c] <= 1'b0;
        end else if (drop_fire[c]) begin
          cause_ff[c] <= 1'b1;
        end else if (rd_take && reg_idx == IDX_LINK_DROP && readdata_ff[CAUSE_LO+c]) begin
          cause_ff[c] <= 1'b0;
        end
      end
    end
  endgenerate

  // R9: receive error latch, cleared by counter read, set wins
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      rx_err_latch_ff <= 1'b0;
    end else if (rx_error_event_in) begin
      rx_err_latch_ff <= 1'b1;
    end else if (rd_take && reg_idx == IDX_RX_ERR_CNT) begin
      rx_err_latch_ff <= 1'b0;
    end
  end

  // receive error counter saturates rather than wrapping to zero
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      rx_err_cnt_ff <= RX_CNT_RST;
    end else if (rd_take && reg_idx == IDX_RX_ERR_CNT) begin
      rx_err_cnt_ff <= {15'h0000, rx_error_event_in};
    end else if (rx_error_event_in && rx_err_cnt_ff != 16'hffff) begin
      rx_err_cnt_ff <= rx_err_cnt_ff + 16'h0001;
    end
  end

  // R10: polarity latch cleared only by a 10base-t status read
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      pol_latch_ff <= 1'b0;
    end else if (inverted_polarity_in) begin
      pol_latch_ff <= 1'b1;
    end else if (rd_take && reg_idx == IDX_TENBASE) begin
      pol_latch_ff <= 1'b0;
    end
  end

  // R11: one while inverted polarity seen or held
  assign pol_view = pol_latch_ff | inverted_polarity_in;

  // interrupt events, as long as their sources; only the ignored-access event is single-cycle
  always_comb begin
    irq_event                = '0;
    irq_event[IRQ_LINK_DROP] = |drop_fire;
    irq_event[IRQ_RX_ERR]    = rx_error_event_in;
    irq_event[IRQ_POLARITY]  = inverted_polarity_in;
    irq_event[IRQ_IGNORED]   = ad_ignored;
  end

  // sticky status, write one to clear, set wins over clear
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      irq_stat_ff <= '0;
    end else if (wr_take && reg_idx == IDX_IRQ_CLEAR && byteenable_in[0]) begin
      irq_stat_ff <= (irq_stat_ff & ~writedata_in[IRQ_W-1:0]) | irq_event;
    end else begin
      irq_stat_ff <= irq_stat_ff | irq_event;
    end
  end

  // interrupt enable register
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      irq_en_ff <= IRQ_EN_RST;
    end else if (wr_take && reg_idx == IDX_IRQ_ENABLE && byteenable_in[0]) begin
      irq_en_ff <= writedata_in[IRQ_W-1:0];
    end
  end

  assign irq_out = |(irq_stat_ff & irq_en_ff);

  // read mux; unmapped and write-only words read zero
  always_comb begin
    read_value = 32'h0000_0000;
    case (reg_idx)
      IDX_ACCESS_CTRL: read_value[15:0] = ctrl_ff;
      // R4: unselected device reads zero
      IDX_ADDR_DATA: begin
        if (dev_ok) begin
          read_value[15:0] = data_mode ? ext_rd : cur_ptr;
        end
      end
      IDX_LINK_DROP: read_value[CAUSE_LO+CAUSE_W-1:CAUSE_LO] = cause_ff;
      IDX_PHY_STATE: begin
        // R8: pair swap status
        read_value[SWAP_BIT]  = mdi_swapped_in;
        read_value[RXERR_BIT] = rx_err_latch_ff;
        read_value[POL_BIT]   = pol_view;
      end
      IDX_RX_ERR_CNT:  read_value[15:0] = rx_err_cnt_ff;
      IDX_TENBASE:     read_value[TENBASE_POL_BIT] = pol_view;
      IDX_DROP_ENABLE: read_value[CAUSE_W-1:0] = drop_en_ff;
      IDX_IRQ_STATUS:  read_value[IRQ_W-1:0] = irq_stat_ff;
      IDX_IRQ_ENABLE:  read_value[IRQ_W-1:0] = irq_en_ff;
      default:         read_value = 32'h0000_0000;
    endcase
  end

endmodule : phy_indirect_access_and_status
`default_nettype wire

// File: sim/phy_status_monitor.sv
// checker: bus handshake timing, link drop cause and status read relations
// assumes it is bound to phy_indirect_access_and_status on one clock domain
`timescale 1ns/100ps
`default_nettype none

module phy_status_monitor
  import ext_regs_pkg::*;
(
  // clock and reset
  input wire logic               clock_in,
  input wire logic               sys_rst_in,
  // bus
  input wire logic [7:0]         address_in,
  input wire logic               read_in,
  input wire logic               write_in,
  input wire logic [31:0]        readdata_out,
  input wire logic               waitrequest_out,
  // events and outputs
  input wire logic [CAUSE_W-1:0] drop_condition_in,
  input wire logic               mdi_swapped_in,
  input wire logic               rx_error_event_in,
  input wire logic               inverted_polarity_in,
  input wire logic               link_drop_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (sys_rst_in);

  // read completes at the edge where waitrequest is seen low
  logic rd_done;
  assign rd_done = read_in && !waitrequest_out;

  wait_first_a:
  assert property (($rose(read_in) || $rose(write_in)) |-> waitrequest_out) else $error("no wait state");
  wait_answer_a:
  assert property ($rose(read_in || write_in) |=> !waitrequest_out) else $error("answer late");
  idle_wait_a:
  assert property (!(read_in || write_in) |-> !waitrequest_out) else $error("wait while idle");
  upper_zero_a:
  assert property (readdata_out[31:16] == 16'h0000) else $error("upper read bits set");
  drop_cause_a:
  assert property (link_drop_out |-> $past(|drop_condition_in)) else $error("drop without cause");
  swap_live_a:
  assert property (rd_done && address_in[7:2] == IDX_PHY_STATE
    |-> readdata_out[SWAP_BIT] == $past(mdi_swapped_in)) else $error("swap bit wrong");
  rxerr_latch_a:
  assert property (rd_done && address_in[7:2] == IDX_PHY_STATE && $past(rx_error_event_in, 2)
    |-> readdata_out[RXERR_BIT]) else $error("rx error not latched");
  pol_live_a:
  assert property (rd_done && address_in[7:2] == IDX_PHY_STATE && $past(inverted_polarity_in)
    |-> readdata_out[POL_BIT]) else $error("polarity bit low");
  cause_rsvd_a:
  assert property (rd_done && address_in[7:2] == IDX_LINK_DROP
    |-> readdata_out[15:9] == 7'h00 && readdata_out[3:0] == 4'h0) else $error("cause reserved set");

  // main scenarios reached
  cover property (rd_done && address_in[7:2] == IDX_PHY_STATE && readdata_out[RXERR_BIT]);
  cover property (link_drop_out);
  cover property (rd_done && address_in[7:2] == IDX_LINK_DROP && readdata_out[8:4] != 5'h00);
endmodule : phy_status_monitor

bind phy_indirect_access_and_status phy_status_monitor mon (
  .clock_in(clock_in), .sys_rst_in(sys_rst_in), .address_in(address_in), .read_in(read_in),
  .write_in(write_in), .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
  .drop_condition_in(drop_condition_in), .mdi_swapped_in(mdi_swapped_in),
  .rx_error_event_in(rx_error_event_in), .inverted_polarity_in(inverted_polarity_in),
  .link_drop_out(link_drop_out)
);

`default_nettype wire

// File: sim/tb.sv
// testbench: register bank driven over avalon-mm, event inputs pulsed
// assumes the checker is attached by the bind in its own file
`timescale 1ns/100ps
`default_nettype none

module tb;
  import ext_regs_pkg::*;
  logic        clock_in             = 1'b0;
  logic        sys_rst_in           = 1'b1;
  logic [7:0]  address_in           = 8'h00;
  logic        read_in              = 1'b0;
  logic        write_in             = 1'b0;
  logic [31:0] writedata_in         = 32'h0;
  logic [3:0]  byteenable_in        = 4'hf;
  logic [4:0]  drop_condition_in    = 5'h00;
  logic        mdi_swapped_in       = 1'b0;
  logic        rx_error_event_in    = 1'b0;
  logic        inverted_polarity_in = 1'b0;
  logic [31:0] readdata_out;
  logic        waitrequest_out;
  logic        link_drop_out;
  logic        irq_out;
  logic [31:0] rd;
  int          err_total            = 0;
  int          comparisons          = 0;

  // rows: op (1 read, 0 write), register index, write data or expected read
  logic [27:0] rows [$] = '{
    28'h10d0000, 28'h10f0000, 28'h1200000, 28'h1210000, 28'h1230000, 28'h03f1234, 28'h13f0000,
    28'h00d0003, 28'h10d0003, 28'h10e000a, 28'h00e0002, 28'h10e0002, 28'h00d4003, 28'h00e1111, 28'h10e1111,
    28'h00d0007, 28'h00e0002, 28'h00d4007, 28'h00e2222, 28'h10e2222, 28'h00d4003, 28'h10e1111,
    28'h00d0003, 28'h00e0004, 28'h00d8003, 28'h00eaaaa, 28'h00ebbbb, 28'h00d0003, 28'h10e0006,
    28'h00e0004, 28'h00d8003, 28'h10eaaaa, 28'h10ebbbb, 28'h00d0003, 28'h10e0006,
    28'h00e0004, 28'h00dc003, 28'h10eaaaa, 28'h10eaaaa, 28'h00ecccc, 28'h10ebbbb,
    28'h00dffff, 28'h10dc01f, 28'h00d001f, 28'h00e0003, 28'h00d401f, 28'h00e5a5a, 28'h10e5a5a,
    28'h00d001f, 28'h00e04d1, 28'h00d801f, 28'h10e0000, 28'h10e0000, 28'h00d001f, 28'h10e04d2,
    28'h1210008, 28'h0220008,
    28'h00d8005, 28'h00e7777, 28'h10e0000, 28'h1210008, 28'h0220008, 28'h1210000, 28'h00d4003, 28'h10ebbbb
  };

  phy_indirect_access_and_status #(.STORE_DEPTH(16), .STORE_AW(4)) dut (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .address_in(address_in), .read_in(read_in),
    .write_in(write_in), .writedata_in(writedata_in), .byteenable_in(byteenable_in),
    .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
    .drop_condition_in(drop_condition_in), .mdi_swapped_in(mdi_swapped_in),
    .rx_error_event_in(rx_error_event_in), .inverted_polarity_in(inverted_polarity_in),
    .link_drop_out(link_drop_out), .irq_out(irq_out)
  );

  always #50 clock_in = ~clock_in;

  task automatic end_sim;
    $display("counts: %0d mismatches in %0d comparisons", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_reg

  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk_reg(what, {31'h0, exp}, {31'h0, got});
  endtask : chk_bit

  // one access; request held until waitrequest is sampled low, then one idle cycle
  task automatic bus(input logic is_rd, input logic [5:0] idx, input logic [15:0] wd, input logic [3:0] be);
    int n;
    address_in    <= {idx, 2'b00};
    read_in       <= is_rd;
    write_in      <= !is_rd;
    writedata_in  <= {16'h0000, wd};
    byteenable_in <= be;
    for (n = 0; n < 16; n++) begin
      @(posedge clock_in);
      if (waitrequest_out === 1'b0) break;
    end
    if (n == 16) begin
      err_total++;
      $display("[ERR] waitrequest expected 0 seen 1");
      end_sim();
    end
    rd = readdata_out;
    read_in  <= 1'b0;
    write_in <= 1'b0;
    @(posedge clock_in);
  endtask : bus

  task automatic wr(input logic [5:0] idx, input logic [15:0] wd);
    bus(1'b0, idx, wd, 4'hf);
  endtask : wr

  task automatic rd_chk(input string what, input logic [5:0] idx, input logic [15:0] exp);
    bus(1'b1, idx, 16'h0000, 4'hf);
    chk_reg(what, {16'h0000, exp}, rd);
  endtask : rd_chk

  // pulse conditions, then look at the registered drop output
  task automatic pulse_drop(input logic [4:0] cond, input logic exp);
    drop_condition_in <= cond;
    @(posedge clock_in);
    drop_condition_in <= 5'h00;
    @(posedge clock_in);
    chk_bit("link drop", exp, link_drop_out);
  endtask : pulse_drop

  initial begin
    repeat (16) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    @(posedge clock_in);
    // ordinary accesses from the table
    foreach (rows[i]) begin
      if (rows[i][24]) begin
        rd_chk($sformatf("row %0d", i), rows[i][21:16], rows[i][15:0]);
      end else begin
        wr(rows[i][21:16], rows[i][15:0]);
      end
    end
    $display("test table done");
    // each cause alone, with interrupt raise and clear
    wr(IDX_IRQ_ENABLE, 16'h0001);
    for (int i = 0; i < CAUSE_W; i++) begin
      wr(IDX_DROP_ENABLE, 16'h0001 << i);
      pulse_drop(5'h1f, 1'b1);
      rd_chk("cause", IDX_LINK_DROP, 16'h0010 << i);
      rd_chk("cause clr", IDX_LINK_DROP, 16'h0000);
      chk_bit("irq set", 1'b1, irq_out);
      wr(IDX_IRQ_CLEAR, 16'h0001);
      chk_bit("irq clr", 1'b0, irq_out);
    end
    // several enables at once, masked interrupt, disabled drop
    wr(IDX_DROP_ENABLE, 16'h001f);
    rd_chk("enables", IDX_DROP_ENABLE, 16'h001f);
    wr(IDX_IRQ_ENABLE, 16'h0000);
    pulse_drop(5'h05, 1'b1);
    rd_chk("causes", IDX_LINK_DROP, 16'h0050);
    chk_bit("irq masked", 1'b0, irq_out);
    rd_chk("irq status", IDX_IRQ_STATUS, 16'h0001);
    wr(IDX_IRQ_CLEAR, 16'h0001);
    wr(IDX_DROP_ENABLE, 16'h0000);
    pulse_drop(5'h1f, 1'b0);
    rd_chk("no cause", IDX_LINK_DROP, 16'h0000);
    $display("test link drop done");
    // swap, receive error latch, polarity latch
    mdi_swapped_in <= 1'b1;
    rd_chk("swap", IDX_PHY_STATE, 16'h4000);
    mdi_swapped_in <= 1'b0;
    rd_chk("normal", IDX_PHY_STATE, 16'h0000);
    rx_error_event_in <= 1'b1;
    @(posedge clock_in);
    rx_error_event_in <= 1'b0;
    rd_chk("rx latch", IDX_PHY_STATE, 16'h2000);
    rd_chk("rx hold", IDX_PHY_STATE, 16'h2000);
    rd_chk("rx count", IDX_RX_ERR_CNT, 16'h0001);
    rd_chk("rx clr", IDX_PHY_STATE, 16'h0000);
    inverted_polarity_in <= 1'b1;
    rd_chk("pol live", IDX_PHY_STATE, 16'h1000);
    inverted_polarity_in <= 1'b0;
    rd_chk("pol hold", IDX_PHY_STATE, 16'h1000);
    bus(1'b1, IDX_TENBASE, 16'h0000, 4'hf);
    chk_reg("tenbase pol", 32'h10, rd & 32'h10);
    rd_chk("pol clr", IDX_PHY_STATE, 16'h0000);
    rd_chk("irq events", IDX_IRQ_STATUS, 16'h0006);
    wr(IDX_IRQ_ENABLE, 16'h0002);
    chk_bit("irq rx", 1'b1, irq_out);
    wr(IDX_IRQ_CLEAR, 16'h0006);
    chk_bit("irq rx clr", 1'b0, irq_out);
    $display("test status done");
    // byte lanes of the control register
    wr(IDX_ACCESS_CTRL, 16'h0000);
    bus(1'b0, IDX_ACCESS_CTRL, 16'hffff, 4'h1);
    rd_chk("lane0", IDX_ACCESS_CTRL, 16'h001f);
    bus(1'b0, IDX_ACCESS_CTRL, 16'hffff, 4'h2);
    rd_chk("lane1", IDX_ACCESS_CTRL, 16'hc01f);
    // reset again in mid-run
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    @(posedge clock_in);
    rd_chk("ctrl rst", IDX_ACCESS_CTRL, 16'h0000);
    rd_chk("enable rst", IDX_DROP_ENABLE, 16'h0000);
    $display("test lanes and reset done");
    end_sim();
  end
endmodule : tb

`default_nettype wire
